// file: include/fto_pkg.sv
`include "fto_regs.svh"

package fto_pkg;

    // ==========================================
    // types
    typedef struct packed {
        logic [15:0] amp;
        logic [15:0] freq;
    } fto_coeff_t;

    typedef enum logic [2:0] {
        FTO_IDLE  = 3'h0,
        FTO_AMP   = 3'h1,
        FTO_FREQ  = 3'h3,
        FTO_GAIN  = 3'h2,
        FTO_APPLY = 3'h6
    } fto_state_t;

    // ==========================================
    // helpers
    function automatic logic [15:0] fto_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
        fto_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // unsigned scale, saturates instead of wrapping so a large gain cannot fold the level
    function automatic logic [15:0] fto_scale(input logic [15:0] a, input logic [15:0] g);
        logic [31:0] p;
        logic [31:0] s;
        p = a * g;
        s = p >> `FTO_GAIN_SHIFT;
        fto_scale = (s[31:16] != 16'h0000) ? 16'hFFFF : s[15:0];
    endfunction

endpackage

// file: include/fto_regs.svh
`ifndef FTO_REGS_SVH
`define FTO_REGS_SVH

// ==========================================
// register indices, byte address = index * 4
`define FTO_IDX_T1_AMP      7'h0E
`define FTO_IDX_T1_FREQ     7'h0F
`define FTO_IDX_T1_TIMER    7'h10
`define FTO_IDX_KEY_DATA    7'h11
`define FTO_IDX_STATUS      7'h12
`define FTO_IDX_CUR_AMP     7'h13
`define FTO_IDX_CUR_FREQ    7'h14
`define FTO_IDX_RELOAD_CTRL 7'h20
`define FTO_IDX_SPACE_AMP   7'h63
`define FTO_IDX_SPACE_FREQ  7'h64
`define FTO_IDX_MARK_AMP    7'h65
`define FTO_IDX_MARK_FREQ   7'h66
`define FTO_IDX_S2M_GAIN    7'h67
`define FTO_IDX_M2S_GAIN    7'h68
`define FTO_IDX_KEY_CTRL    7'h6C
`define FTO_MEM_BASE        7'h63
`define FTO_MEM_LAST        7'h68

// ==========================================
// field positions
`define FTO_BIT_RELOAD_EN 6
`define FTO_BIT_KEY_EN    6
`define FTO_BIT_TONE_EN   0
`define FTO_BIT_DATA      0

// ==========================================
// reset values and arithmetic
`define FTO_RST_WORD   16'h0000
`define FTO_RST_BIT    1'b1
`define FTO_GAIN_SHIFT 14

// ==========================================
// timing
`define FTO_SAMPLE_NS 125000
`define FTO_CLK_NS    10

`endif

// file: tb/fsk_tone_oscillator_reload_tb.sv
`timescale 1ns/1ps
`include "fto_regs.svh"

module fsk_tone_oscillator_reload_tb import fto_pkg::*;;
    // ==========================================
    // clock, reset and design
    localparam int DIV = 8;
    localparam int TIMER = 40;
    localparam int PERIOD = (TIMER + 1) * DIV;
    logic ref_clk;
    logic sys_rst;
    logic [8:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] tone1_level;
    logic tone1_level_valid;
    logic keying_active;
    int n_mismatch = 0;
    int total_checks = 0;
    integer seed = 51;
    logic [15:0] coef [6];
    logic [15:0] norm_amp;
    logic [15:0] norm_freq;
    logic [15:0] rd;
    logic [15:0] w1;
    logic [15:0] w2;

    fto_fsk_tone_osc #(.SAMPLE_DIV(DIV)) uut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .tone1_level(tone1_level),
        .tone1_level_valid(tone1_level_valid),
        .keying_active(keying_active)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================
    // reporting
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // unsigned Q2.14 gain, clipped at full scale rather than wrapped
    function automatic logic [15:0] exp_scale(input logic [15:0] a, input logic [15:0] g);
        logic [31:0] p;
        p = ({16'h0000, a} * {16'h0000, g}) >> 14;
        exp_scale = (p[31:16] != 16'h0000) ? 16'hFFFF : p[15:0];
    endfunction

    // ==========================================
    // bus master: one request held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [6:0] idx, input logic [15:0] wd,
                            input logic [1:0] be, output logic [15:0] data);
        int n;
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {16'h0000, wd};
        avs_byteenable <= {2'b00, be};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        data = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
            finish_test();
        end
    endtask

    task automatic wr16(input logic [6:0] idx, input logic [15:0] wd);
        logic [15:0] dummy;
        bus_xfer(1'b1, idx, wd, 2'b11, dummy);
    endtask

    task automatic rd16(input logic [6:0] idx, output logic [15:0] data);
        bus_xfer(1'b0, idx, 16'h0000, 2'b11, data);
    endtask

    // waits for the expiry that shows {current, previous} bits, then reads the live words
    task automatic keyed_step(input logic [1:0] pair, input logic [15:0] amp, input logic [15:0] freq);
        logic [15:0] st;
        int n;
        n = 0;
        do begin
            rd16(`FTO_IDX_STATUS, st);
            n++;
        end while ((st[2:1] !== pair || st[0] !== 1'b1) && n < 3 * PERIOD);
        if (n >= 3 * PERIOD) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, st, {13'h0000, pair, 1'b1});
            finish_test();
        end
        repeat (4) @(posedge ref_clk);
        rd16(`FTO_IDX_CUR_AMP, st);
        check16(st, amp);
        rd16(`FTO_IDX_CUR_FREQ, st);
        check16(st, freq);
    endtask

    // waits for the next level strobe; a lost strobe ends the run
    task automatic wait_level();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (tone1_level_valid !== 1'b1 && n < 4 * DIV);
        if (n >= 4 * DIV) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, tone1_level_valid, 1'b1);
            finish_test();
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        avs_address = 9'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check1(avs_waitrequest, 1'b1);
        check1(keying_active, 1'b0);
        // coefficient words come up cleared, then hold random values
        for (int i = 0; i < 6; i++) begin
            rd16(`FTO_MEM_BASE + 7'(i), rd);
            check16(rd, 16'h0000);
            coef[i] = 16'($random(seed));
            wr16(`FTO_MEM_BASE + 7'(i), coef[i]);
            rd16(`FTO_MEM_BASE + 7'(i), rd);
            check16(rd, coef[i]);
        end
        // low lane only, high byte must survive
        w1 = coef[4];
        w2 = 16'($random(seed));
        bus_xfer(1'b1, `FTO_IDX_S2M_GAIN, w2, 2'b01, rd);
        coef[4] = {w1[15:8], w2[7:0]};
        rd16(`FTO_IDX_S2M_GAIN, rd);
        check16(rd, coef[4]);
        // largest gain on the mark-to-space edge to hit the clip corner
        coef[5] = 16'hFFFF;
        wr16(`FTO_IDX_M2S_GAIN, coef[5]);
        // unmapped and read-only places
        wr16(7'h7F, 16'hA5A5);
        rd16(7'h7F, rd);
        check16(rd, 16'h0000);
        wr16(`FTO_IDX_CUR_AMP, 16'h5A5A);
        rd16(`FTO_IDX_CUR_AMP, rd);
        check16(rd, 16'h0000);
        // tone with reload but no keying: normal words stay in charge
        norm_amp = 16'($random(seed));
        norm_freq = 16'($random(seed));
        wr16(`FTO_IDX_T1_AMP, norm_amp);
        wr16(`FTO_IDX_T1_FREQ, norm_freq);
        wr16(`FTO_IDX_T1_TIMER, 16'(TIMER));
        wr16(`FTO_IDX_KEY_DATA, 16'h0000);
        wr16(`FTO_IDX_RELOAD_CTRL, 16'h0041);
        repeat (2 * PERIOD) @(posedge ref_clk);
        check1(keying_active, 1'b0);
        rd16(`FTO_IDX_CUR_AMP, rd);
        check16(rd, norm_amp);
        rd16(`FTO_IDX_CUR_FREQ, rd);
        check16(rd, norm_freq);
        // keying on: space, space, mark, mark
        wr16(`FTO_IDX_KEY_CTRL, 16'h0040);
        repeat (3) @(posedge ref_clk);
        check1(keying_active, 1'b1);
        keyed_step(2'b01, exp_scale(coef[0], coef[5]), coef[1]);
        // status already shows a repeated bit once the edge is applied, so let a whole bit pass
        repeat (PERIOD) @(posedge ref_clk);
        keyed_step(2'b00, coef[0], coef[1]);
        wr16(`FTO_IDX_KEY_DATA, 16'h0001);
        keyed_step(2'b10, exp_scale(coef[2], coef[4]), coef[3]);
        repeat (PERIOD) @(posedge ref_clk);
        keyed_step(2'b11, coef[2], coef[3]);
        // reload enable dropped with keying still set: back to normal words
        wr16(`FTO_IDX_RELOAD_CTRL, 16'h0001);
        repeat (3) @(posedge ref_clk);
        check1(keying_active, 1'b0);
        repeat (2 * PERIOD) @(posedge ref_clk);
        rd16(`FTO_IDX_CUR_AMP, rd);
        check16(rd, norm_amp);
        rd16(`FTO_IDX_CUR_FREQ, rd);
        check16(rd, norm_freq);
        // a zero normal amplitude must silence the level; strobes come once per sample
        wr16(`FTO_IDX_T1_AMP, 16'h0000);
        repeat (2 * PERIOD) @(posedge ref_clk);
        wait_level();
        check16(tone1_level, 16'h0000);
        repeat (DIV - 1) @(posedge ref_clk);
        check1(tone1_level_valid, 1'b0);
        @(posedge ref_clk);
        check1(tone1_level_valid, 1'b1);
        finish_test();
    end

    // ==========================================
    // hang guard
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        finish_test();
    end
endmodule

// file: verilog/fto_coeff_mem.sv
`timescale 1ns/1ps

module fto_coeff_mem #(
    parameter int W = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] a_addr,
    input wire logic a_we,
    input wire logic [W-1:0] a_wdata,
    output logic [W-1:0] a_rdata,
    input wire logic [AW-1:0] b_addr,
    output logic [W-1:0] b_rdata
);
    logic [W-1:0] mem_reg [DEPTH];
    logic [W-1:0] a_rdata_reg;
    logic [W-1:0] b_rdata_reg;

    // ==========================================
    // storage, cleared so that an unwritten word reads as zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (a_we) begin
            mem_reg[a_addr] <= a_wdata;
        end
    end

    // ==========================================
    // registered read ports
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            a_rdata_reg <= '0;
            b_rdata_reg <= '0;
        end else begin
            a_rdata_reg <= mem_reg[a_addr];
            b_rdata_reg <= mem_reg[b_addr];
        end
    end

    assign a_rdata = a_rdata_reg;
    assign b_rdata = b_rdata_reg;
endmodule

// file: verilog/fto_fsk_tone_osc.sv
`timescale 1ns/1ps
`include "fto_regs.svh"

// Behaviour
// R1: space bit takes space amplitude word
// R2: space bit takes space frequency word
// R3: mark bit takes mark amplitude word
// R4: mark bit takes mark frequency word
// R5: with keying on, timer expiry loads keying words, not normal
// R6: space-to-mark scales amplitude by its gain
// R7: mark-to-space scales amplitude by its gain
// R8: keying needs both enable bits set
// R9: phase kept across coefficient swaps
module fto_fsk_tone_osc import fto_pkg::*; #(
    parameter int SAMPLE_DIV = `FTO_SAMPLE_NS / `FTO_CLK_NS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [15:0] tone1_level,
    output logic tone1_level_valid,
    output logic keying_active
);
    // ==========================================
    // declarations
    logic [6:0] bus_idx;
    logic req;
    logic in_mem;
    logic pend_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [15:0] reload_ctrl_reg;
    logic [15:0] key_ctrl_reg;
    logic [15:0] t1_amp_reg;
    logic [15:0] t1_freq_reg;
    logic [15:0] t1_timer_reg;
    logic [15:0] key_data_reg;
    logic [15:0] timer_cnt_reg;
    logic [15:0] mem_a_rdata;
    logic [15:0] eng_rdata;
    logic [2:0] eng_addr;
    logic [2:0] bus_off;
    logic mem_we;
    logic tick;
    logic tone_en;
    logic keying_on;
    logic expire;
    logic bit_reg;
    logic prev_bit_reg;
    logic [15:0] amp_fetch_reg;
    logic [15:0] freq_fetch_reg;
    fto_coeff_t cur_reg;
    fto_state_t state_reg;
    logic [15:0] phase_reg;
    logic [15:0] level_reg;
    logic level_valid_reg;
    logic active_reg;
    logic [15:0] tri_wave;
    logic [1:0] be16;

    function automatic logic [2:0] mem_off(input logic [6:0] idx);
        logic [6:0] d;
        d = idx - `FTO_MEM_BASE;
        mem_off = d[2:0];
    endfunction

    // ==========================================
    // bus slave
    assign bus_idx = avs_address[8:2];
    assign req = avs_read | avs_write;
    assign be16 = avs_byteenable[1:0];
    assign in_mem = (bus_idx >= `FTO_MEM_BASE) && (bus_idx <= `FTO_MEM_LAST);
    assign bus_off = mem_off(bus_idx);
    assign mem_we = pend_reg & avs_write & in_mem;

    // two-cycle answer: the first edge starts the word fetch, the second answers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_reg <= 1'b0;
            wait_reg <= 1'b1;
        end else if (pend_reg) begin
            pend_reg <= 1'b0;
            wait_reg <= 1'b0;
        end else begin
            pend_reg <= req & wait_reg;
            wait_reg <= 1'b1;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (in_mem) begin
            rdata_next[15:0] = mem_a_rdata;
        end else begin
            unique case (bus_idx)
                `FTO_IDX_T1_AMP: rdata_next[15:0] = t1_amp_reg;
                `FTO_IDX_T1_FREQ: rdata_next[15:0] = t1_freq_reg;
                `FTO_IDX_T1_TIMER: rdata_next[15:0] = t1_timer_reg;
                `FTO_IDX_KEY_DATA: rdata_next[15:0] = key_data_reg;
                `FTO_IDX_STATUS: rdata_next[3:0] = {keying_on, bit_reg, prev_bit_reg, active_reg};
                `FTO_IDX_CUR_AMP: rdata_next[15:0] = cur_reg.amp;
                `FTO_IDX_CUR_FREQ: rdata_next[15:0] = cur_reg.freq;
                `FTO_IDX_RELOAD_CTRL: rdata_next[15:0] = reload_ctrl_reg;
                `FTO_IDX_KEY_CTRL: rdata_next[15:0] = key_ctrl_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (pend_reg & avs_read) begin
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================
    // software registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reload_ctrl_reg <= `FTO_RST_WORD;
            key_ctrl_reg <= `FTO_RST_WORD;
            t1_amp_reg <= `FTO_RST_WORD;
            t1_freq_reg <= `FTO_RST_WORD;
            t1_timer_reg <= `FTO_RST_WORD;
            key_data_reg <= `FTO_RST_WORD;
        end else if (pend_reg & avs_write) begin
            unique case (bus_idx)
                `FTO_IDX_T1_AMP: t1_amp_reg <= fto_merge(t1_amp_reg, avs_writedata[15:0], be16);
                `FTO_IDX_T1_FREQ: t1_freq_reg <= fto_merge(t1_freq_reg, avs_writedata[15:0], be16);
                `FTO_IDX_T1_TIMER: t1_timer_reg <= fto_merge(t1_timer_reg, avs_writedata[15:0], be16);
                `FTO_IDX_KEY_DATA: key_data_reg <= fto_merge(key_data_reg, avs_writedata[15:0], be16);
                `FTO_IDX_RELOAD_CTRL: reload_ctrl_reg <= fto_merge(reload_ctrl_reg, avs_writedata[15:0], be16);
                `FTO_IDX_KEY_CTRL: key_ctrl_reg <= fto_merge(key_ctrl_reg, avs_writedata[15:0], be16);
                default: ;
            endcase
        end
    end

    fto_coeff_mem #(.W(16), .DEPTH(8), .AW(3)) u_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .a_addr(bus_off),
        .a_we(mem_we),
        .a_wdata(fto_merge(mem_a_rdata, avs_writedata[15:0], be16)),
        .a_rdata(mem_a_rdata),
        .b_addr(eng_addr),
        .b_rdata(eng_rdata)
    );

    // ==========================================
    // sample rate and active timer
    fto_tick_div #(.DIV(SAMPLE_DIV)) u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    assign tone_en = reload_ctrl_reg[`FTO_BIT_TONE_EN];
    assign keying_on = reload_ctrl_reg[`FTO_BIT_RELOAD_EN] & key_ctrl_reg[`FTO_BIT_KEY_EN]; // [R8]
    assign expire = tick & tone_en & (timer_cnt_reg == 16'h0000) & (state_reg == FTO_IDLE);

    // timer counts samples; a busy fetch delays expiry by a sample, never loses it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_cnt_reg <= `FTO_RST_WORD;
        end else if (!tone_en) begin
            timer_cnt_reg <= t1_timer_reg;
        end else if (expire) begin
            timer_cnt_reg <= t1_timer_reg;
        end else if (tick && timer_cnt_reg != 16'h0000) begin
            timer_cnt_reg <= timer_cnt_reg - 16'h0001;
        end
    end

    // ==========================================
    // keying fetch engine
    always_comb begin
        unique case (state_reg)
            FTO_AMP: eng_addr = bit_reg ? mem_off(`FTO_IDX_MARK_AMP) : mem_off(`FTO_IDX_SPACE_AMP); // [R1] [R3]
            FTO_FREQ: eng_addr = bit_reg ? mem_off(`FTO_IDX_MARK_FREQ) : mem_off(`FTO_IDX_SPACE_FREQ); // [R2] [R4]
            FTO_GAIN: eng_addr = bit_reg ? mem_off(`FTO_IDX_S2M_GAIN) : mem_off(`FTO_IDX_M2S_GAIN); // [R6] [R7]
            default: eng_addr = 3'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= FTO_IDLE;
        end else begin
            unique case (state_reg)
                FTO_IDLE: state_reg <= (expire && keying_on) ? FTO_AMP : FTO_IDLE; // [R5]
                FTO_AMP: state_reg <= FTO_FREQ;
                FTO_FREQ: state_reg <= FTO_GAIN;
                FTO_GAIN: state_reg <= FTO_APPLY;
                FTO_APPLY: state_reg <= FTO_IDLE;
                default: state_reg <= FTO_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bit_reg <= `FTO_RST_BIT;
        end else if (expire && keying_on) begin
            bit_reg <= key_data_reg[`FTO_BIT_DATA];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            amp_fetch_reg <= `FTO_RST_WORD;
            freq_fetch_reg <= `FTO_RST_WORD;
        end else begin
            if (state_reg == FTO_FREQ) begin
                amp_fetch_reg <= eng_rdata;
            end
            if (state_reg == FTO_GAIN) begin
                freq_fetch_reg <= eng_rdata;
            end
        end
    end

    // line idles at mark, so the first space after enabling counts as a transition
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_bit_reg <= `FTO_RST_BIT;
        end else if (!keying_on) begin
            prev_bit_reg <= `FTO_RST_BIT;
        end else if (state_reg == FTO_APPLY) begin
            prev_bit_reg <= bit_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_reg <= '0;
        end else if (expire && !keying_on) begin
            cur_reg <= '{amp: t1_amp_reg, freq: t1_freq_reg};
        end else if (state_reg == FTO_APPLY) begin
            cur_reg.freq <= freq_fetch_reg; // [R5]
            cur_reg.amp <= (bit_reg != prev_bit_reg) ? fto_scale(amp_fetch_reg, eng_rdata) : amp_fetch_reg; // [R6] [R7]
        end
    end

    // ==========================================
    // oscillator
    assign tri_wave = phase_reg[15] ? {~phase_reg[14:0], 1'b0} : {phase_reg[14:0], 1'b0};

    // phase accumulator is never cleared on reload, so keying stays phase-continuous
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= `FTO_RST_WORD;
        end else if (tick && tone_en) begin
            phase_reg <= phase_reg + cur_reg.freq; // [R9]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            level_reg <= `FTO_RST_WORD;
            level_valid_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            level_valid_reg <= tick & tone_en;
            active_reg <= keying_on & tone_en;
            if (tick && tone_en) begin
                level_reg <= fto_scale(tri_wave, cur_reg.amp);
            end
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign tone1_level = level_reg;
    assign tone1_level_valid = level_valid_reg;
    assign keying_active = active_reg;

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_space_amp;
        state_reg == FTO_FREQ && !bit_reg |-> eng_rdata == u_mem.mem_reg[mem_off(`FTO_IDX_SPACE_AMP)];
    endproperty
    a_space_amp: assert property (p_space_amp) else $error("space amplitude word not fetched"); // [R1]

    property p_space_freq;
        state_reg == FTO_GAIN && !bit_reg |=> freq_fetch_reg == u_mem.mem_reg[mem_off(`FTO_IDX_SPACE_FREQ)];
    endproperty
    a_space_freq: assert property (p_space_freq) else $error("space frequency word not fetched"); // [R2]

    property p_mark_amp;
        state_reg == FTO_FREQ && bit_reg |=> amp_fetch_reg == u_mem.mem_reg[mem_off(`FTO_IDX_MARK_AMP)];
    endproperty
    a_mark_amp: assert property (p_mark_amp) else $error("mark amplitude word not fetched"); // [R3]

    property p_mark_freq;
        state_reg == FTO_GAIN && bit_reg |-> eng_rdata == u_mem.mem_reg[mem_off(`FTO_IDX_MARK_FREQ)];
    endproperty
    a_mark_freq: assert property (p_mark_freq) else $error("mark frequency word not fetched"); // [R4]

    property p_expiry_load;
        expire && keying_on |=> state_reg == FTO_AMP ##3 state_reg == FTO_APPLY ##1
            cur_reg.freq == $past(freq_fetch_reg) && state_reg == FTO_IDLE;
    endproperty
    a_expiry_load: assert property (p_expiry_load) else $error("keying words not loaded at expiry"); // [R5]

    property p_gain_up;
        state_reg == FTO_APPLY && bit_reg && !prev_bit_reg |->
            eng_rdata == u_mem.mem_reg[mem_off(`FTO_IDX_S2M_GAIN)] ##1
            cur_reg.amp == fto_scale($past(amp_fetch_reg), $past(eng_rdata));
    endproperty
    a_gain_up: assert property (p_gain_up) else $error("space to mark gain not applied"); // [R6]

    property p_gain_down;
        state_reg == FTO_APPLY && !bit_reg && prev_bit_reg |->
            eng_rdata == u_mem.mem_reg[mem_off(`FTO_IDX_M2S_GAIN)] ##1
            cur_reg.amp == fto_scale($past(amp_fetch_reg), $past(eng_rdata));
    endproperty
    a_gain_down: assert property (p_gain_down) else $error("mark to space gain not applied"); // [R7]

    property p_normal_load;
        expire && !keying_on |=> state_reg == FTO_IDLE && cur_reg.amp == $past(t1_amp_reg)
            && cur_reg.freq == $past(t1_freq_reg);
    endproperty
    a_normal_load: assert property (p_normal_load) else $error("normal words not loaded"); // [R8]

    property p_phase_cont;
        tick && tone_en |=> phase_reg == 16'($past(phase_reg) + $past(cur_reg.freq));
    endproperty
    a_phase_cont: assert property (p_phase_cont) else $error("phase not continuous"); // [R9]

    c_up: cover property (state_reg == FTO_APPLY && bit_reg && !prev_bit_reg);
    c_down: cover property (state_reg == FTO_APPLY && !bit_reg && prev_bit_reg);
    c_normal: cover property (expire && !keying_on);
    c_bus: cover property (pend_reg && avs_write && in_mem);
endmodule

// file: verilog/fto_tick_div.sv
`timescale 1ns/1ps

module fto_tick_div #(
    parameter int DIV = 12500
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_reg;
    logic tick_reg;

    // ==========================================
    // divider
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (cnt_reg == CW'(DIV - 1)) begin
            cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;
endmodule
